// >>> include/pcsbc_pkg.sv
// Purpose: shared constants and types of the clock generator stop/break control
// Assumes: 32-bit classic Wishbone, byte lane 0 holds each 8-bit register
// Notes: register words are one aligned 32-bit word each
package pcsbc_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [7:0] PLL_CTRL_OFS = 8'h00;
    localparam logic [7:0] BANDWIDTH_CTRL_OFS = 8'h04;
    localparam logic [7:0] BREAK_FLAG_CTRL_OFS = 8'h08;
    localparam logic [7:0] IRQ_STATUS_OFS = 8'h0C;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h10;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int PLL_CTRL_REG_IRQ_EN_BIT = 7;
    localparam int PLL_CTRL_REG_FLAG_BIT = 6;
    localparam int PLL_CTRL_REG_PON_BIT = 5;
    localparam int PLL_CTRL_REG_BCS_BIT = 4;
    localparam logic [7:0] PLL_CTRL_REG_UNIMPL_ONES = 8'h0F;
    localparam int BANDWIDTH_CTRL_REG_AUTO_BIT = 7;
    localparam int BANDWIDTH_CTRL_REG_LOCK_BIT = 6;
    localparam int BANDWIDTH_CTRL_REG_TRK_BIT = 5;
    localparam int BREAK_FLAG_CTRL_REG_BREAK_CLEAR_ENABLE_BIT = 7;
    localparam int IRQ_W = 3;
    localparam int IRQ_LOCK_CHG_BIT = 0;
    localparam int IRQ_TRK_BIT = 1;
    localparam int IRQ_LOCK_BIT = 2;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic RST_IRQ_EN = 1'b0;
    localparam logic RST_PON = 1'b1;
    localparam logic RST_BCS = 1'b0;
    localparam logic RST_AUTO = 1'b0;
    localparam logic RST_TRK_MANUAL = 1'b0;
    localparam logic RST_BREAK_CLEAR_ENABLE = 1'b0;
    localparam logic [2:0] RST_IRQ_MASK = 3'h0;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_SWITCH = 2'b01,
        ST_HALT = 2'b10
    } pcsbc_state_e;

    typedef struct packed {
        logic xtal;
        logic vco;
        logic sel_vco;
        logic halt;
    } pcsbc_div_s;

endpackage

// >>> core/pcsbc_clkdiv.sv
// Purpose: divide-by-two base clock selector driving the bus clock output
// Assumes: crystal and vco levels are sampled synchronous to clk_sys
// Notes: source changes only while the output is low
`timescale 1ns/1ps
module pcsbc_clkdiv (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire pcsbc_pkg::pcsbc_div_s cfg,
    output logic bus_clk,
    output logic vco_active
);

    logic xtal_prev_reg;
    logic xtal_prev_next;
    logic vco_prev_reg;
    logic vco_prev_next;
    logic div_reg;
    logic div_next;
    logic sel_reg;
    logic sel_next;
    logic src_edge;

    // switching only at a low output keeps every bus clock pulse full width
    always_comb begin
        xtal_prev_next = cfg.xtal;
        vco_prev_next = cfg.vco;
        sel_next = sel_reg;
        div_next = div_reg;
        src_edge = sel_reg ? (cfg.vco & ~vco_prev_reg) : (cfg.xtal & ~xtal_prev_reg);
        if (cfg.halt) begin
            div_next = 1'b0;
            sel_next = 1'b0;
        end else begin
            if (src_edge) begin
                div_next = ~div_reg;
            end
            if (!div_reg && !src_edge) begin
                sel_next = cfg.sel_vco;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            xtal_prev_reg <= 1'b0;
            vco_prev_reg <= 1'b0;
            div_reg <= 1'b0;
            sel_reg <= 1'b0;
        end else begin
            xtal_prev_reg <= xtal_prev_next;
            vco_prev_reg <= vco_prev_next;
            div_reg <= div_next;
            sel_reg <= sel_next;
        end
    end

    assign bus_clk = div_reg;
    assign vco_active = sel_reg;

endmodule // pcsbc_clkdiv

// >>> core/pcsbc_core.sv
// Purpose: clock generator control: stop entry/exit, break protection, lock status
// Assumes: single clk_sys at 10 MHz, classic Wishbone slave, inputs synchronous
// Notes: analog loop reports its tolerance checks on trk_tol_met and lock_tol_met
`timescale 1ns/1ps

// What this block does
// - stop disables the generator and holds crystal, bus clock and irq outputs low
// - stop entry with vco selected clears base clock select, back to crystal
// - after stop the bus clock is crystal divided by two, select stays clear
// - during break, status clears work only when break clear enable is one
// - a status bit cleared in break stays cleared after break ends
// - during break with break clear enable zero, control register access keeps lock change flag
// - in auto mode the tracking bit sets when error drops below tracking tolerance
// - in auto mode the lock bit sets when error drops below lock tolerance
// - timing figures only hold for initial frequency errors within plus or minus 100%
// - refuse clearing power-on while select set, and setting select while power off
// - auto mode: lock changes set the flag; irq only with irq enable set
// - manual mode reads lock and flag as zero and suppresses pll irq
module pcsbc_core (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic xtal_osc_in,
    input wire logic vco_clock,
    input wire logic stop_mode,
    input wire logic break_active,
    input wire logic trk_tol_met,
    input wire logic lock_tol_met,
    output logic crystal_ref_clock,
    output logic bus_clock_out,
    output logic pll_irq_out,
    output logic pll_power_out,
    output logic tracking_mode_out
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    pcsbc_pkg::pcsbc_state_e state_reg;
    pcsbc_pkg::pcsbc_state_e state_next;
    logic ack_reg;
    logic ack_next;
    logic [31:0] dat_reg;
    logic [31:0] dat_next;
    logic irq_en_reg;
    logic irq_en_next;
    logic pon_reg;
    logic pon_next;
    logic bcs_reg;
    logic bcs_next;
    logic auto_reg;
    logic auto_next;
    logic trk_man_reg;
    logic trk_man_next;
    logic break_clear_enable_reg;
    logic break_clear_enable_next;
    logic trk_reg;
    logic trk_next;
    logic lock_reg;
    logic lock_next;
    logic flag_reg;
    logic flag_next;
    logic [2:0] irq_st_reg;
    logic [2:0] irq_st_next;
    logic [2:0] irq_mask_reg;
    logic [2:0] irq_mask_next;
    logic xclk_reg;
    logic xclk_next;
    logic irq_out_reg;
    logic irq_out_next;

    logic req;
    logic wr_fire;
    logic rd_fire;
    logic clear_ok;
    logic halt;
    logic div_vco;
    logic lock_chg;
    logic [7:0] wdat;
    pcsbc_pkg::pcsbc_div_s div_cfg;

    function automatic logic [7:0] read_mux(input logic [7:0] adr);
        logic [7:0] v;
        v = 8'h00;
        case (adr)
            pcsbc_pkg::PLL_CTRL_OFS: begin
                v = pcsbc_pkg::PLL_CTRL_REG_UNIMPL_ONES;
                v[pcsbc_pkg::PLL_CTRL_REG_IRQ_EN_BIT] = irq_en_reg;
                v[pcsbc_pkg::PLL_CTRL_REG_FLAG_BIT] = flag_reg & auto_reg;
                v[pcsbc_pkg::PLL_CTRL_REG_PON_BIT] = pon_reg;
                v[pcsbc_pkg::PLL_CTRL_REG_BCS_BIT] = bcs_reg;
            end
            pcsbc_pkg::BANDWIDTH_CTRL_OFS: begin
                v[pcsbc_pkg::BANDWIDTH_CTRL_REG_AUTO_BIT] = auto_reg;
                v[pcsbc_pkg::BANDWIDTH_CTRL_REG_LOCK_BIT] = lock_reg & auto_reg;
                v[pcsbc_pkg::BANDWIDTH_CTRL_REG_TRK_BIT] = auto_reg ? trk_reg : trk_man_reg;
            end
            pcsbc_pkg::BREAK_FLAG_CTRL_OFS: begin
                v[pcsbc_pkg::BREAK_FLAG_CTRL_REG_BREAK_CLEAR_ENABLE_BIT] = break_clear_enable_reg;
            end
            pcsbc_pkg::IRQ_STATUS_OFS: begin
                v[2:0] = irq_st_reg;
            end
            pcsbc_pkg::IRQ_MASK_OFS: begin
                v[2:0] = irq_mask_reg;
            end
            default: begin
                v = 8'h00;
            end
        endcase
        return v;
    endfunction

    // ----------------------------------------------------------------
    // bus slave: data latched on request, effects at the ack edge
    // ----------------------------------------------------------------
    assign req = wb_cyc_i & wb_stb_i;
    assign wr_fire = req & ack_reg & wb_we_i & wb_sel_i[0];
    assign rd_fire = req & ack_reg & ~wb_we_i;
    assign wdat = wb_dat_i[7:0];
    assign halt = (state_reg == pcsbc_pkg::ST_HALT);
    // protection only while break input is high
    assign clear_ok = ~break_active | break_clear_enable_reg;

    always_comb begin
        ack_next = req & ~ack_reg;
        dat_next = dat_reg;
        if (req && !ack_reg) begin
            dat_next = {24'h000000, read_mux(wb_adr_i)};
        end
    end

    // ----------------------------------------------------------------
    // stop sequencing
    // ----------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            pcsbc_pkg::ST_RUN: begin
                if (stop_mode) begin
                    state_next = pcsbc_pkg::ST_SWITCH;
                end
            end
            pcsbc_pkg::ST_SWITCH: begin
                // wait for the divider to sit on crystal
                if (!stop_mode) begin
                    state_next = pcsbc_pkg::ST_RUN;
                end else if (!div_vco && !bcs_reg && !bus_clock_out) begin
                    state_next = pcsbc_pkg::ST_HALT;
                end
            end
            pcsbc_pkg::ST_HALT: begin
                if (!stop_mode) begin
                    state_next = pcsbc_pkg::ST_RUN;
                end
            end
            default: begin
                state_next = pcsbc_pkg::ST_RUN;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    always_comb begin
        irq_en_next = irq_en_reg;
        pon_next = pon_reg;
        bcs_next = bcs_reg;
        auto_next = auto_reg;
        trk_man_next = trk_man_reg;
        break_clear_enable_next = break_clear_enable_reg;
        irq_mask_next = irq_mask_reg;
        if (wr_fire) begin
            case (wb_adr_i)
                pcsbc_pkg::PLL_CTRL_OFS: begin
                    irq_en_next = wdat[pcsbc_pkg::PLL_CTRL_REG_IRQ_EN_BIT];
                    // power-on clear refused while select set
                    if (wdat[pcsbc_pkg::PLL_CTRL_REG_PON_BIT] || !bcs_reg) begin
                        pon_next = wdat[pcsbc_pkg::PLL_CTRL_REG_PON_BIT];
                    end
                    // select set refused while power off; no select while stopping
                    if (!wdat[pcsbc_pkg::PLL_CTRL_REG_BCS_BIT] || (pon_reg && state_reg == pcsbc_pkg::ST_RUN)) begin
                        bcs_next = wdat[pcsbc_pkg::PLL_CTRL_REG_BCS_BIT];
                    end
                end
                pcsbc_pkg::BANDWIDTH_CTRL_OFS: begin
                    auto_next = wdat[pcsbc_pkg::BANDWIDTH_CTRL_REG_AUTO_BIT];
                    if (!auto_reg) begin
                        trk_man_next = wdat[pcsbc_pkg::BANDWIDTH_CTRL_REG_TRK_BIT];
                    end
                end
                pcsbc_pkg::BREAK_FLAG_CTRL_OFS: begin
                    break_clear_enable_next = wdat[pcsbc_pkg::BREAK_FLAG_CTRL_REG_BREAK_CLEAR_ENABLE_BIT];
                end
                pcsbc_pkg::IRQ_MASK_OFS: begin
                    irq_mask_next = wdat[2:0];
                end
                default: begin
                    irq_mask_next = irq_mask_reg;
                end
            endcase
        end
        // stop entry drops select; it stays clear until rewritten
        if (state_reg != pcsbc_pkg::ST_RUN) begin
            bcs_next = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // acquisition, lock and flags
    // ----------------------------------------------------------------
    // tolerance inputs are trusted only for starts within +-100% error
    always_comb begin
        trk_next = auto_reg & pon_reg & ~halt & trk_tol_met;
        lock_next = auto_reg & pon_reg & ~halt & trk_tol_met & lock_tol_met;
        lock_chg = auto_reg & (lock_next != lock_reg);
        flag_next = flag_reg;
        irq_st_next = irq_st_reg;
        // read clears only when allowed; no restore afterwards
        if (rd_fire && clear_ok && wb_adr_i == pcsbc_pkg::PLL_CTRL_OFS) begin
            flag_next = 1'b0;
        end
        if (rd_fire && clear_ok && wb_adr_i == pcsbc_pkg::IRQ_STATUS_OFS) begin
            irq_st_next = 3'h0;
        end
        // manual mode holds the flag at zero
        if (!auto_reg) begin
            flag_next = 1'b0;
        end
        // lock change sets flag; a set wins over a clear
        if (lock_chg) begin
            flag_next = 1'b1;
        end
        irq_st_next[pcsbc_pkg::IRQ_LOCK_CHG_BIT] = irq_st_next[pcsbc_pkg::IRQ_LOCK_CHG_BIT] | lock_chg;
        irq_st_next[pcsbc_pkg::IRQ_TRK_BIT] = irq_st_next[pcsbc_pkg::IRQ_TRK_BIT] | (trk_next & ~trk_reg);
        irq_st_next[pcsbc_pkg::IRQ_LOCK_BIT] = irq_st_next[pcsbc_pkg::IRQ_LOCK_BIT] | (lock_next & ~lock_reg);
        // request gated by enable, auto mode and stop
        irq_out_next = (state_next != pcsbc_pkg::ST_HALT) & auto_reg & irq_en_reg & ((|(irq_st_reg & irq_mask_reg))
                       | flag_reg);
        // crystal output held low while stopped
        xclk_next = (state_next != pcsbc_pkg::ST_HALT) & xtal_osc_in;
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= pcsbc_pkg::ST_RUN;
            ack_reg <= 1'b0;
            dat_reg <= 32'h00000000;
            irq_en_reg <= pcsbc_pkg::RST_IRQ_EN;
            pon_reg <= pcsbc_pkg::RST_PON;
            bcs_reg <= pcsbc_pkg::RST_BCS;
            auto_reg <= pcsbc_pkg::RST_AUTO;
            trk_man_reg <= pcsbc_pkg::RST_TRK_MANUAL;
            break_clear_enable_reg <= pcsbc_pkg::RST_BREAK_CLEAR_ENABLE;
            irq_mask_reg <= pcsbc_pkg::RST_IRQ_MASK;
            trk_reg <= 1'b0;
            lock_reg <= 1'b0;
            flag_reg <= 1'b0;
            irq_st_reg <= 3'h0;
            xclk_reg <= 1'b0;
            irq_out_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            ack_reg <= ack_next;
            dat_reg <= dat_next;
            irq_en_reg <= irq_en_next;
            pon_reg <= pon_next;
            bcs_reg <= bcs_next;
            auto_reg <= auto_next;
            trk_man_reg <= trk_man_next;
            break_clear_enable_reg <= break_clear_enable_next;
            irq_mask_reg <= irq_mask_next;
            trk_reg <= trk_next;
            lock_reg <= lock_next;
            flag_reg <= flag_next;
            irq_st_reg <= irq_st_next;
            xclk_reg <= xclk_next;
            irq_out_reg <= irq_out_next;
        end
    end

    // ----------------------------------------------------------------
    // base clock divider and outputs
    // ----------------------------------------------------------------
    always_comb begin
        div_cfg.xtal = xtal_osc_in;
        div_cfg.vco = vco_clock;
        div_cfg.sel_vco = bcs_reg;
        // divider frozen low from the stop decision on, no cut pulse
        div_cfg.halt = halt | (state_next == pcsbc_pkg::ST_HALT);
    end

    pcsbc_clkdiv u_div (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .cfg(div_cfg),
        .bus_clk(bus_clock_out),
        .vco_active(div_vco)
    );

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;
    assign crystal_ref_clock = xclk_reg;
    assign pll_irq_out = irq_out_reg;
    assign pll_power_out = pon_reg & ~halt;
    assign tracking_mode_out = auto_reg ? trk_reg : trk_man_reg;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_stop_outputs_low: assert property (
        (state_reg == pcsbc_pkg::ST_HALT) ##1 (state_reg == pcsbc_pkg::ST_HALT)
        |-> !bus_clock_out && !crystal_ref_clock && !pll_irq_out)
        else $error("outputs not low in stop");
    a_stop_bcs_clear: assert property (
        (state_reg == pcsbc_pkg::ST_SWITCH) |=> !bcs_reg)
        else $error("select not cleared on stop entry");
    a_wake_bcs_clear: assert property (
        $past(state_reg == pcsbc_pkg::ST_HALT) && (state_reg == pcsbc_pkg::ST_RUN) |-> !bcs_reg && !div_vco)
        else $error("select set after stop recovery");
    a_break_flag_hold: assert property (
        break_active && !break_clear_enable_reg && flag_reg && auto_reg ##1 auto_reg |-> flag_reg)
        else $error("flag lost during protected break");
    a_break_flag_clear: assert property (
        rd_fire && break_active && break_clear_enable_reg && wb_adr_i == pcsbc_pkg::PLL_CTRL_OFS && !lock_chg |=> !flag_reg)
        else $error("flag clear ignored with clear enable");
    a_trk_set: assert property (
        auto_reg && pon_reg && !halt && trk_tol_met |=> trk_reg)
        else $error("tracking bit not set");
    a_lock_set: assert property (
        auto_reg && pon_reg && !halt && trk_tol_met && lock_tol_met |=> lock_reg ##1 1'b1)
        else $error("lock bit not set");
    a_pon_guard: assert property (
        bcs_reg |=> pon_reg)
        else $error("power cleared while select set");
    a_bcs_guard: assert property (
        $rose(bcs_reg) |-> $past(pon_reg))
        else $error("select set while power off");
    a_lock_flag: assert property (
        auto_reg && $changed(lock_reg) |-> flag_reg)
        else $error("flag missing after lock change");
    a_irq_gate: assert property (
        pll_irq_out |-> $past(auto_reg) && $past(irq_en_reg))
        else $error("irq without auto mode and enable");
    a_switch_first: assert property (
        $rose(state_reg == pcsbc_pkg::ST_HALT) |-> !div_vco && !bus_clock_out ##1 !bus_clock_out)
        else $error("stop forced before source switch");

    c_stop_cycle: cover property (
        (state_reg == pcsbc_pkg::ST_HALT) ##[1:50] (state_reg == pcsbc_pkg::ST_RUN));
    c_break_clear: cover property (rd_fire && break_active && break_clear_enable_reg && flag_reg);
    c_lock_irq: cover property ($rose(lock_reg) ##[1:10] pll_irq_out);

endmodule // pcsbc_core

// >>> tb/pcsbc_partner.sv
// Purpose: far side model: crystal and vco sources, analog tolerance detectors
// Assumes: bench requests tolerance states on trk_req and lock_req
// Notes: detectors settle two cycles after a request, like a slow loop filter
`timescale 1ns/1ps
module pcsbc_partner (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic trk_req,
    input wire logic lock_req,
    output logic xtal_osc_in,
    output logic vco_clock,
    output logic trk_tol_met,
    output logic lock_tol_met
);
    logic [1:0] div_reg;
    logic [1:0] tol_reg;
    // free running sources: crystal period 4 cycles, vco period 2 cycles
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            div_reg <= 2'h0;
            tol_reg <= 2'h0;
            trk_tol_met <= 1'b0;
            lock_tol_met <= 1'b0;
        end else begin
            div_reg <= div_reg + 2'h1;
            tol_reg <= {lock_req, trk_req};
            trk_tol_met <= tol_reg[0];
            lock_tol_met <= tol_reg[1] & tol_reg[0];
        end
    end
    assign xtal_osc_in = div_reg[1];
    assign vco_clock = div_reg[0];
endmodule // pcsbc_partner

// >>> tb/pll_clock_stop_break_control_tb_top.sv
// Purpose: register level test of stop, break and lock behaviour
// Assumes: master waits for ack, lock bits follow detectors
// Notes: pins sampled on falling edge; bus answer taken at the ack edge
`timescale 1ns/1ps
module pll_clock_stop_break_control_tb_top;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0;
    logic [31:0] rdat;
    logic ack;
    logic xtal, vco, trk, lck, stop = 1'b0, brk = 1'b0, trq = 1'b0, lrq = 1'b0;
    logic xref, bclk, irq, pwr, tmode;
    int n_fail = 0;
    int checks_done = 0;
    int n;
    always #50 clk_sys = ~clk_sys;
    pcsbc_partner i_partner (.clk_sys(clk_sys), .rst_n(rst_n), .trk_req(trq), .lock_req(lrq),
        .xtal_osc_in(xtal), .vco_clock(vco), .trk_tol_met(trk), .lock_tol_met(lck));
    pcsbc_core i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .xtal_osc_in(xtal), .vco_clock(vco), .stop_mode(stop), .break_active(brk), .trk_tol_met(trk),
        .lock_tol_met(lck), .crystal_ref_clock(xref), .bus_clock_out(bclk), .pll_irq_out(irq),
        .pll_power_out(pwr), .tracking_mode_out(tmode));
    task automatic end_of_test();
        if (n_fail == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_pin(input logic got, input logic exp);
        cmp_reg({31'h0, got}, {31'h0, exp});
    endtask
    task automatic wait_cyc(input int k);
        repeat (k) @(negedge clk_sys);
    endtask
    task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int i;
        @(posedge clk_sys);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        i = 0;
        do begin
            @(posedge clk_sys);
            i++;
        end while (ack !== 1'b1 && i < 20);
        if (ack !== 1'b1) begin
            n_fail++;
            end_of_test();
        end
        q = rdat;
        cyc <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        wb_cycle(1'b1, a, {24'h0, d}, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        logic [31:0] q;
        wb_cycle(1'b0, a, 32'h0, q);
        cmp_reg(q, {24'h0, e});
    endtask
    task automatic count_rises(output int c);
        logic p;
        c = 0;
        p = bclk;
        repeat (32) begin
            @(negedge clk_sys);
            if (bclk === 1'b1 && p === 1'b0) c++;
            p = bclk;
        end
    endtask
    initial begin
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        wait_cyc(2);
        // reset values and unmapped place
        cmp_pin(pwr, 1'b1);
        rd(pcsbc_pkg::PLL_CTRL_OFS, 8'h2F);
        rd(pcsbc_pkg::BANDWIDTH_CTRL_OFS, 8'h00);
        rd(pcsbc_pkg::BREAK_FLAG_CTRL_OFS, 8'h00);
        rd(pcsbc_pkg::IRQ_MASK_OFS, 8'h00);
        wr(8'h20, 8'hFF);
        rd(8'h20, 8'h00);
        // select and power interlock
        wr(pcsbc_pkg::PLL_CTRL_OFS, 8'h00);
        wr(pcsbc_pkg::PLL_CTRL_OFS, 8'h10);
        rd(pcsbc_pkg::PLL_CTRL_OFS, 8'h0F);
        wr(pcsbc_pkg::PLL_CTRL_OFS, 8'h20);
        wr(pcsbc_pkg::PLL_CTRL_OFS, 8'h30);
        wr(pcsbc_pkg::PLL_CTRL_OFS, 8'h10);
        rd(pcsbc_pkg::PLL_CTRL_OFS, 8'h3F);
        // stop entry from vco source and recovery
        count_rises(n);
        cmp_reg(32'(n), 32'h8);
        @(posedge clk_sys);
        stop <= 1'b1;
        wait_cyc(10);
        repeat (8) begin
            @(negedge clk_sys);
            cmp_reg({29'h0, xref, bclk, irq}, 32'h0);
        end
        cmp_pin(pwr, 1'b0);
        rd(pcsbc_pkg::PLL_CTRL_OFS, 8'h2F);
        @(posedge clk_sys);
        stop <= 1'b0;
        wait_cyc(4);
        count_rises(n);
        cmp_reg(32'(n), 32'h4);
        rd(pcsbc_pkg::PLL_CTRL_OFS, 8'h2F);
        // automatic mode acquisition and lock
        wr(pcsbc_pkg::BANDWIDTH_CTRL_OFS, 8'h80);
        trq <= 1'b1;
        wait_cyc(6);
        rd(pcsbc_pkg::BANDWIDTH_CTRL_OFS, 8'hA0);
        cmp_pin(tmode, 1'b1);
        lrq <= 1'b1;
        wait_cyc(6);
        rd(pcsbc_pkg::BANDWIDTH_CTRL_OFS, 8'hE0);
        cmp_pin(irq, 1'b0);
        rd(pcsbc_pkg::PLL_CTRL_OFS, 8'h6F);
        rd(pcsbc_pkg::PLL_CTRL_OFS, 8'h2F);
        rd(pcsbc_pkg::IRQ_STATUS_OFS, 8'h07);
        rd(pcsbc_pkg::IRQ_STATUS_OFS, 8'h00);
        wr(pcsbc_pkg::PLL_CTRL_OFS, 8'hA0);
        lrq <= 1'b0;
        wait_cyc(6);
        cmp_pin(irq, 1'b1);
        rd(pcsbc_pkg::IRQ_STATUS_OFS, 8'h01);
        rd(pcsbc_pkg::PLL_CTRL_OFS, 8'hEF);
        wait_cyc(2);
        cmp_pin(irq, 1'b0);
        // break protection of flag and status
        @(posedge clk_sys);
        brk <= 1'b1;
        lrq <= 1'b1;
        wait_cyc(6);
        rd(pcsbc_pkg::PLL_CTRL_OFS, 8'hEF);
        rd(pcsbc_pkg::PLL_CTRL_OFS, 8'hEF);
        rd(pcsbc_pkg::IRQ_STATUS_OFS, 8'h05);
        rd(pcsbc_pkg::IRQ_STATUS_OFS, 8'h05);
        wr(pcsbc_pkg::BREAK_FLAG_CTRL_OFS, 8'h80);
        rd(pcsbc_pkg::BREAK_FLAG_CTRL_OFS, 8'h80);
        rd(pcsbc_pkg::PLL_CTRL_OFS, 8'hEF);
        rd(pcsbc_pkg::PLL_CTRL_OFS, 8'hAF);
        rd(pcsbc_pkg::IRQ_STATUS_OFS, 8'h05);
        @(posedge clk_sys);
        brk <= 1'b0;
        rd(pcsbc_pkg::PLL_CTRL_OFS, 8'hAF);
        rd(pcsbc_pkg::IRQ_STATUS_OFS, 8'h00);
        // masked status source
        wr(pcsbc_pkg::IRQ_MASK_OFS, 8'h04);
        lrq <= 1'b0;
        wait_cyc(6);
        rd(pcsbc_pkg::PLL_CTRL_OFS, 8'hEF);
        wait_cyc(2);
        cmp_pin(irq, 1'b0);
        wr(pcsbc_pkg::IRQ_MASK_OFS, 8'h01);
        wait_cyc(2);
        cmp_pin(irq, 1'b1);
        rd(pcsbc_pkg::IRQ_STATUS_OFS, 8'h01);
        wait_cyc(2);
        cmp_pin(irq, 1'b0);
        // manual mode hides lock and flag
        @(posedge clk_sys);
        lrq <= 1'b1;
        wait_cyc(6);
        wr(pcsbc_pkg::BANDWIDTH_CTRL_OFS, 8'h00);
        rd(pcsbc_pkg::BANDWIDTH_CTRL_OFS, 8'h00);
        rd(pcsbc_pkg::PLL_CTRL_OFS, 8'hAF);
        cmp_pin(irq, 1'b0);
        cmp_pin(tmode, 1'b0);
        wr(pcsbc_pkg::BANDWIDTH_CTRL_OFS, 8'h20);
        rd(pcsbc_pkg::BANDWIDTH_CTRL_OFS, 8'h20);
        cmp_pin(tmode, 1'b1);
        end_of_test();
    end
endmodule // pll_clock_stop_break_control_tb_top
